// File: core/cprs_pkg.sv
// Purpose: Shared constants and types of the configuration memory readout sequencer.
// Assumes: One system clock of 200 MHz; all pins sampled as synchronous inputs.
// Notes:   Scan opcodes here are arbitrary choices of this design.
package cprs_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_PS   = 5000;
   localparam int POR_HOLD_NS     = 50;
   localparam int POR_HOLD_CYC    = (POR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RELOAD_PULSE_NS = 100;
   localparam int RELOAD_CYC      = (RELOAD_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TIMER_W         = 6;

   // ----------------------------------------------------------------
   // Data path
   // ----------------------------------------------------------------
   localparam int WORD_W      = 8;
   localparam int BIT_SEL_W   = 3;
   localparam int SHARED_BIT  = 4;
   localparam logic [WORD_W-1:0] OE_PARALLEL = 8'hFF;
   localparam logic [WORD_W-1:0] OE_SERIAL   = 8'h01;

   // ----------------------------------------------------------------
   // Scan instruction register
   // ----------------------------------------------------------------
   localparam int IR_W = 8;
   localparam logic [IR_W-1:0] IR_BYPASS    = 8'hFF;
   localparam logic [IR_W-1:0] IR_RELOAD    = 8'hEE;
   localparam logic [IR_W-1:0] IR_ISP_ENTER = 8'hE8;
   localparam logic [IR_W-1:0] IR_ISP_EXIT  = 8'hF0;
   localparam logic [IR_W-1:0] IR_CAPTURE   = 8'h01;

   typedef enum logic [3:0] {
      TAP_RESET   = 4'h0,
      TAP_IDLE    = 4'h1,
      TAP_SEL_DR  = 4'h2,
      TAP_CAP_DR  = 4'h3,
      TAP_SH_DR   = 4'h4,
      TAP_EX1_DR  = 4'h5,
      TAP_PA_DR   = 4'h6,
      TAP_EX2_DR  = 4'h7,
      TAP_UP_DR   = 4'h8,
      TAP_SEL_IR  = 4'h9,
      TAP_CAP_IR  = 4'hA,
      TAP_SH_IR   = 4'hB,
      TAP_EX1_IR  = 4'hC,
      TAP_PA_IR   = 4'hD,
      TAP_EX2_IR  = 4'hE,
      TAP_UP_IR   = 4'hF
   } cprs_tap_state_t;

endpackage

// File: core/cprs_tap_if.sv
// Purpose: Carries scan controller results to the readout core.
// Assumes: Both ends run on clk_in.
// Notes:   reload_pulse is one clk_in cycle wide.
`timescale 1ns/1ps
`default_nettype none
interface cprs_tap_if;
   logic reload_pulse;
   logic isp_active;
   logic tdo;
   logic tdo_oe;

   modport tap  (output reload_pulse, output isp_active, output tdo, output tdo_oe);
   modport core (input  reload_pulse, input  isp_active, input  tdo, input  tdo_oe);
endinterface
`default_nettype wire

// File: core/cprs_tap.sv
// Purpose: Scan test access port controller paced by the sampled test clock.
// Assumes: tck_in, tms_in, tdi_in are synchronous to clk_in and tck is much slower.
// Notes:   Every data register choice reads as the one-bit bypass path.
`timescale 1ns/1ps
`default_nettype none
module cprs_tap (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic tck_in,
   input  wire logic tms_in,
   input  wire logic tdi_in,
   cprs_tap_if.tap   tap
);
   import cprs_pkg::*;

   typedef struct packed {
      logic             tck_prev;
      cprs_tap_state_t  state;
      logic [IR_W-1:0]  ir_sh;
      logic [IR_W-1:0]  ir;
      logic             byp;
      logic             tdo;
      logic             tdo_oe;
      logic             isp;
      logic             reload;
   } cprs_tap_st_t;

   cprs_tap_st_t st_q;
   cprs_tap_st_t st_d;
   logic         tck_rise;
   logic         tck_fall;

   // Standard sixteen-state walk chosen by the sampled mode select.
   function automatic cprs_tap_state_t cprs_tap_next(input cprs_tap_state_t s, input logic m);
      case (s)
         TAP_RESET:  cprs_tap_next = m ? TAP_RESET  : TAP_IDLE;
         TAP_IDLE:   cprs_tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: cprs_tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: cprs_tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR:  cprs_tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: cprs_tap_next = m ? TAP_UP_DR  : TAP_PA_DR;
         TAP_PA_DR:  cprs_tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: cprs_tap_next = m ? TAP_UP_DR  : TAP_SH_DR;
         TAP_UP_DR:  cprs_tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: cprs_tap_next = m ? TAP_RESET  : TAP_CAP_IR;
         TAP_CAP_IR: cprs_tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR:  cprs_tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: cprs_tap_next = m ? TAP_UP_IR  : TAP_PA_IR;
         TAP_PA_IR:  cprs_tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: cprs_tap_next = m ? TAP_UP_IR  : TAP_SH_IR;
         TAP_UP_IR:  cprs_tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         default:    cprs_tap_next = TAP_RESET;
      endcase
   endfunction

   assign tck_rise = tck_in & ~st_q.tck_prev;
   assign tck_fall = ~tck_in & st_q.tck_prev;

   // Shift on test clock rise, present output on test clock fall.
   always_comb begin
      st_d          = st_q;
      st_d.tck_prev = tck_in;
      st_d.reload   = 1'b0;
      if (tck_rise) begin
         case (st_q.state)
            TAP_RESET: begin
               st_d.ir  = IR_BYPASS;
               st_d.isp = 1'b0;
            end
            TAP_CAP_IR: st_d.ir_sh = IR_CAPTURE;
            TAP_SH_IR:  st_d.ir_sh = {tdi_in, st_q.ir_sh[IR_W-1:1]};
            TAP_CAP_DR: st_d.byp = 1'b0;
            TAP_SH_DR:  st_d.byp = tdi_in;
            TAP_UP_IR: begin
               st_d.ir = st_q.ir_sh;
               if (st_q.ir_sh == IR_RELOAD) begin
                  st_d.reload = 1'b1;
               end
               if (st_q.ir_sh == IR_ISP_ENTER) begin
                  st_d.isp = 1'b1;
               end else if (st_q.ir_sh == IR_ISP_EXIT) begin
                  st_d.isp = 1'b0;
               end
            end
            default: st_d.ir = st_q.ir;
         endcase
         st_d.state = cprs_tap_next(st_q.state, tms_in);
      end
      if (tck_fall) begin
         st_d.tdo    = (st_q.state == TAP_SH_IR) ? st_q.ir_sh[0] : st_q.byp;
         st_d.tdo_oe = (st_q.state == TAP_SH_IR) || (st_q.state == TAP_SH_DR);
      end
   end

   // Register the whole controller state.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= '{tck_prev: 1'b0, state: TAP_RESET, ir_sh: IR_BYPASS, ir: IR_BYPASS,
                   byp: 1'b0, tdo: 1'b1, tdo_oe: 1'b0, isp: 1'b0, reload: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign tap.reload_pulse = st_q.reload;
   assign tap.isp_active   = st_q.isp;
   assign tap.tdo          = st_q.tdo;
   assign tap.tdo_oe       = st_q.tdo_oe;

endmodule
`default_nettype wire

// File: core/cprs_top.sv
// Purpose: Readout sequencer of a cascadable configuration memory.
// Assumes: Read clock, select and gate pins are synchronous to clk_in and slower.
// Notes:   Memory contents are written through the prog port while programming.
`timescale 1ns/1ps
`default_nettype none
module cprs_top #(
   parameter int ADDR_W = 10,
   parameter logic [ADDR_W-1:0] LAST_ADDR = '1
) (
   input  wire logic                       clk_in,
   input  wire logic                       rst_in,
   input  wire logic                       read_clk_in,
   input  wire logic                       chip_select_n_in,
   input  wire logic                       out_gate_rst_n_in,
   output var  logic                       out_gate_rst_n_out,
   output var  logic                       out_gate_rst_n_oe_out,
   input  wire logic                       serial_mode_in,
   input  wire logic                       reload_to_bit4_option_in,
   output var  logic [cprs_pkg::WORD_W-1:0] parallel_data_out,
   output var  logic [cprs_pkg::WORD_W-1:0] parallel_data_oe_out,
   output var  logic                       serial_data_out,
   output var  logic                       cascade_enable_out_n_out,
   output var  logic                       reload_request_n_out,
   output var  logic                       reload_request_n_oe_out,
   input  wire logic                       tck_in,
   input  wire logic                       tms_in,
   input  wire logic                       tdi_in,
   output var  logic                       tdo_out,
   output var  logic                       tdo_oe_out,
   input  wire logic                       prog_we_in,
   input  wire logic [ADDR_W-1:0]          prog_addr_in,
   input  wire logic [cprs_pkg::WORD_W-1:0] prog_data_in
);
   import cprs_pkg::*;

   localparam int CNT_W = ADDR_W + BIT_SEL_W;
   localparam logic [TIMER_W-1:0] POR_LOAD    = TIMER_W'(POR_HOLD_CYC);
   localparam logic [TIMER_W-1:0] RELOAD_LOAD = TIMER_W'(RELOAD_CYC);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic               rclk_prev;
      logic [CNT_W-1:0]   cnt;
      logic               past_end;
      logic [WORD_W-1:0]  dout;
      logic [WORD_W-1:0]  doe;
      logic               ceo_n;
      logic [TIMER_W-1:0] por_cnt;
      logic               gate_low_oe;
      logic [TIMER_W-1:0] rl_cnt;
      logic               rl_oe;
   } cprs_st_t;

   cprs_st_t          st_q;
   cprs_st_t          st_d;
   logic [WORD_W-1:0] mem [2**ADDR_W];
   cprs_tap_if        tap_bus ();

   logic              enable;
   logic              read_rise;
   logic [CNT_W-1:0]  last_limit;
   logic [ADDR_W-1:0] word_idx;
   logic [WORD_W-1:0] word;
   logic [BIT_SEL_W-1:0] bit_sel;
   logic              shared_reload;

   // ----------------------------------------------------------------
   // Scan controller
   // ----------------------------------------------------------------
   cprs_tap u_tap (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .tck_in (tck_in),
      .tms_in (tms_in),
      .tdi_in (tdi_in),
      .tap    (tap_bus.tap)
   );

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Writes are only honoured while programming, when the data pins float and the gate pin is held low.
   always_ff @(posedge clk_in) begin
      if (prog_we_in && tap_bus.isp_active) begin
         mem[prog_addr_in] <= prog_data_in;
      end
   end

   // ----------------------------------------------------------------
   // Readout decode
   // ----------------------------------------------------------------
   // The device counts only when selected, ungated and not being programmed.
   assign enable    = ~chip_select_n_in & out_gate_rst_n_in & ~tap_bus.isp_active;
   assign read_rise = read_clk_in & ~st_q.rclk_prev;

   // In serial mode the counter addresses bits, so the mark covers the whole last word.
   assign last_limit = serial_mode_in ? {LAST_ADDR, {BIT_SEL_W{1'b1}}}
                                      : {{BIT_SEL_W{1'b0}}, LAST_ADDR};

   assign shared_reload = reload_to_bit4_option_in & serial_mode_in;

   // Next state of the sequencer.
   always_comb begin
      st_d           = st_q;
      st_d.rclk_prev = read_clk_in;
      word_idx       = '0;
      word           = '0;
      bit_sel        = '0;

      // Counter: held at zero unless enabled, saturates past the mark.
      if (!enable) begin
         st_d.cnt      = '0;
         st_d.past_end = 1'b0;
      end else if (read_rise && !st_q.past_end) begin
         if (st_q.cnt == last_limit) begin
            st_d.past_end = 1'b1;
         end else begin
            st_d.cnt = st_q.cnt + CNT_W'(1);
         end
      end

      // Word fetch for the address that the counter will hold next.
      if (serial_mode_in) begin
         word_idx = st_d.cnt[CNT_W-1:BIT_SEL_W];
         bit_sel  = st_d.cnt[BIT_SEL_W-1:0];
      end else begin
         word_idx = st_d.cnt[ADDR_W-1:0];
      end
      word = mem[word_idx];

      // Data pins: most significant bit first in serial mode.
      if (enable && !st_d.past_end) begin
         if (serial_mode_in) begin
            st_d.dout = {{(WORD_W-1){1'b0}}, word[3'(WORD_W-1) - bit_sel]};
            st_d.doe  = OE_SERIAL;
         end else begin
            st_d.dout = word;
            st_d.doe  = OE_PARALLEL;
         end
      end else begin
         st_d.dout = '0;
         st_d.doe  = '0;
      end

      // Cascade output follows the three conditions directly.
      st_d.ceo_n = ~(~chip_select_n_in & out_gate_rst_n_in & st_d.past_end);

      // Internal reset hold after power-up reset, and during programming.
      if (st_q.por_cnt != '0) begin
         st_d.por_cnt = st_q.por_cnt - TIMER_W'(1);
      end
      st_d.gate_low_oe = (st_d.por_cnt != '0) | tap_bus.isp_active;

      // Reload request pulse, restarted by each reload command.
      if (tap_bus.reload_pulse) begin
         st_d.rl_cnt = RELOAD_LOAD;
      end else if (st_q.rl_cnt != '0) begin
         st_d.rl_cnt = st_q.rl_cnt - TIMER_W'(1);
      end
      st_d.rl_oe = (st_d.rl_cnt != '0) & ~tap_bus.isp_active;

      // Shared pin carries the open-drain reload request instead of data.
      if (shared_reload) begin
         st_d.dout[SHARED_BIT] = 1'b0;
         st_d.doe[SHARED_BIT]  = st_d.rl_oe;
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // The gate pin is pulled low from reset until the hold count runs out.
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= '{rclk_prev: 1'b0, cnt: '0, past_end: 1'b0, dout: '0, doe: '0,
                   ceo_n: 1'b1, por_cnt: POR_LOAD, gate_low_oe: 1'b1,
                   rl_cnt: '0, rl_oe: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Open-drain pins only ever drive low; the enable decides.
   assign out_gate_rst_n_out       = 1'b0;
   assign out_gate_rst_n_oe_out    = st_q.gate_low_oe;
   assign reload_request_n_out     = 1'b0;
   assign reload_request_n_oe_out  = st_q.rl_oe;
   assign parallel_data_out        = st_q.dout;
   assign parallel_data_oe_out     = st_q.doe;
   assign serial_data_out          = st_q.dout[0];
   assign cascade_enable_out_n_out = st_q.ceo_n;
   assign tdo_out                  = tap_bus.tdo;
   assign tdo_oe_out               = tap_bus.tdo_oe;

endmodule
`default_nettype wire

// File: verif/cprs_asserts.sv
// Purpose: Port-level checks of the readout sequencer top.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes:   Bound into every top instance at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module cprs_asserts (
   input wire logic       clk_in,
   input wire logic       rst_in,
   input wire logic       read_clk_in,
   input wire logic       chip_select_n_in,
   input wire logic       out_gate_rst_n_in,
   input wire logic       out_gate_rst_n_oe_out,
   input wire logic [7:0] parallel_data_out,
   input wire logic [7:0] parallel_data_oe_out,
   input wire logic       cascade_enable_out_n_out,
   input wire logic       reload_request_n_oe_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // Deselect or a low gate must float the data pins one cycle later.
   property p_cs_float; chip_select_n_in |=> parallel_data_oe_out == '0; endproperty
   a_cs_float: assert property (p_cs_float) else $error("data driven while deselected");
   property p_gate_float; !out_gate_rst_n_in |=> parallel_data_oe_out == '0; endproperty
   a_gate_float: assert property (p_gate_float) else $error("data driven while gated");
   // The cascade output may only be low while selected and ungated.
   property p_casc_high; chip_select_n_in || !out_gate_rst_n_in |=> cascade_enable_out_n_out; endproperty
   a_casc_high: assert property (p_casc_high) else $error("cascade not released");
   property p_casc_cause; !cascade_enable_out_n_out |-> $past(!chip_select_n_in && out_gate_rst_n_in); endproperty
   a_casc_cause: assert property (p_casc_cause) else $error("cascade low without cause");
   // The own reset holds the gate wire low, which in turn keeps the data pins off.
   property p_por_hold; $fell(rst_in) |-> out_gate_rst_n_oe_out [*8]; endproperty
   a_por_hold: assert property (p_por_hold) else $error("gate not held after reset");
   property p_own_reset; out_gate_rst_n_oe_out |=> parallel_data_oe_out == '0; endproperty
   a_own_reset: assert property (p_own_reset) else $error("data driven during own reset");
   // The reload pulse stays high for its first eight cycles and is low again twenty cycles after it rises.
   property p_reload; $rose(reload_request_n_oe_out) |-> reload_request_n_oe_out [*8] ##13 !reload_request_n_oe_out;
   endproperty
   a_reload: assert property (p_reload) else $error("reload pulse width wrong");
   // Driven data may only step after a counted read clock rise.
   property p_step; $changed(parallel_data_out) && $past(parallel_data_oe_out) != '0 && parallel_data_oe_out != '0
      |-> $past(read_clk_in) && !$past(read_clk_in, 2) && !$past(chip_select_n_in); endproperty
   a_step: assert property (p_step) else $error("data stepped without read clock");
   c_casc: cover property (!cascade_enable_out_n_out);
   c_reload: cover property ($rose(reload_request_n_oe_out));
   c_serial: cover property (parallel_data_oe_out == 8'h01);
endmodule
bind cprs_top cprs_asserts u_chk (.clk_in(clk_in), .rst_in(rst_in), .read_clk_in(read_clk_in),
   .chip_select_n_in(chip_select_n_in), .out_gate_rst_n_in(out_gate_rst_n_in),
   .out_gate_rst_n_oe_out(out_gate_rst_n_oe_out), .parallel_data_out(parallel_data_out),
   .parallel_data_oe_out(parallel_data_oe_out), .cascade_enable_out_n_out(cascade_enable_out_n_out),
   .reload_request_n_oe_out(reload_request_n_oe_out));
`default_nettype wire

// File: verif/cprs_host_model.sv
// Purpose: Configuration port of the logic device that reads the memory.
// Assumes: Every step is taken on a falling edge of clk_in.
// Notes:   The read clock stands still between calls.
`timescale 1ns/1ps
`default_nettype none
module cprs_host_model (
   input  wire logic clk_in,
   input  wire logic gate_wire_in,
   output var  logic read_clk_out,
   output var  logic cs_n_out,
   output var  logic gate_pull_out
);
   // Idle: deselected, gate released, read clock low.
   initial begin
      read_clk_out = 1'b0;
      cs_n_out = 1'b1;
      gate_pull_out = 1'b0;
   end

   // Reading waits until the memory lets the gate wire rise, bounded.
   task automatic sel(input logic cs_n, input logic pull);
      int t;
      t = 0;
      @(negedge clk_in);
      cs_n_out = cs_n;
      gate_pull_out = pull;
      while (!pull && gate_wire_in !== 1'b1 && t < 400) begin
         @(negedge clk_in);
         t++;
      end
   endtask

   // One read clock period; slow stretches both phases beyond one cycle.
   task automatic rise(input int slow);
      @(negedge clk_in);
      read_clk_out = 1'b1;
      repeat (1 + slow) @(negedge clk_in);
      read_clk_out = 1'b0;
      repeat (1 + slow) @(negedge clk_in);
   endtask
endmodule
`default_nettype wire

// File: verif/cprs_top_tb.sv
// Purpose: Self-checking bench of the configuration memory readout sequencer.
// Assumes: Inputs change on falling clk edges; the image lives in a bench queue.
// Notes:   A short last address keeps frames brief yet reaches the cascade hand-off.
`timescale 1ns/1ps
`default_nettype none
module config_prom_readout_sequencer_tb;
   import cprs_pkg::*;
   localparam logic [9:0] LAST_A = 10'h00F;
   logic       clk, rst, ser, opt, tck, tms, tdi, we, goe, sdo, casc, roe, tdo, tdoe, rclk, csn, pull;
   logic [9:0] addr;
   logic [7:0] wdata, pd, poe;
   logic [7:0] mem [$];
   int         bad_count = 0;
   int         comparisons = 0;
   wire        gate = !(goe || pull);

   // Free-running system clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   cprs_top #(.ADDR_W(10), .LAST_ADDR(LAST_A)) dut (
      .clk_in(clk), .rst_in(rst), .read_clk_in(rclk), .chip_select_n_in(csn), .out_gate_rst_n_in(gate),
      .out_gate_rst_n_out(), .out_gate_rst_n_oe_out(goe), .serial_mode_in(ser), .reload_to_bit4_option_in(opt),
      .parallel_data_out(pd), .parallel_data_oe_out(poe), .serial_data_out(sdo), .cascade_enable_out_n_out(casc),
      .reload_request_n_out(), .reload_request_n_oe_out(roe), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
      .tdo_out(tdo), .tdo_oe_out(tdoe), .prog_we_in(we), .prog_addr_in(addr), .prog_data_in(wdata));
   cprs_host_model host (.clk_in(clk), .gate_wire_in(gate), .read_clk_out(rclk), .cs_n_out(csn),
      .gate_pull_out(pull));

   // Every check funnels through here so the tallies stay honest.
   task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (bad_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // One slow scan clock period; mode select is set well before the rise.
   task automatic jt(input logic ms, input logic di, output logic [1:0] o);
      tck = 1'b0;
      tms = ms;
      tdi = di;
      repeat (5) @(negedge clk);
      o = {tdoe, tdo};
      tck = 1'b1;
      repeat (5) @(negedge clk);
   endtask
   // From idle, shift an opcode LSB first and return to idle.
   task automatic load_ir(input logic [7:0] op);
      logic [1:0] o;
      for (int i = 0; i < 4; i++)
         jt(i < 2, 1'b1, o);
      for (int i = 0; i < 8; i++) begin
         jt(i == 7, op[i], o);
         cmp_data({6'h00, o}, {6'h00, 1'b1, i == 0});
      end
      jt(1'b1, 1'b1, o);
      jt(1'b0, 1'b1, o);
   endtask

   // Read a whole frame; at step ab the host pulls the gate low and restarts.
   task automatic frame(input logic s, input int ab);
      int k;
      logic [7:0] ex;
      k = 0;
      ser = s;
      host.sel(1'b0, 1'b0);
      repeat (2) @(negedge clk);
      // Serial mode reads eight bits per word, so the whole image takes eight times as many rises.
      while (k < (s ? 128 : 16)) begin
         ex = s ? {7'h00, mem[k/8][7-k%8]} : mem[k];
         cmp_data(s ? {7'h00, sdo} : pd, ex);
         cmp_data(poe, s ? OE_SERIAL : OE_PARALLEL);
         cmp_data({7'h00, casc}, 8'h01);
         if (k == ab) begin
            host.sel(1'b0, 1'b1);
            repeat (2) @(negedge clk);
            cmp_data({casc, poe[6:0]}, 8'h80);
            host.rise(0);
            host.sel(1'b0, 1'b0);
            repeat (2) @(negedge clk);
            k = 0;
            ab = -1;
         end else begin
            host.rise($urandom_range(2));
            k++;
         end
      end
      cmp_data({casc, poe[6:0]}, 8'h00);
      host.rise(0);
      cmp_data(poe, 8'h00);
      host.sel(1'b1, 1'b0);
      repeat (2) @(negedge clk);
      cmp_data({casc, poe[6:0]}, 8'h80);
   endtask

   // Reload command while selected in serial mode, with no read clock rises; width and bit-four routing are checked.
   task automatic reload(input logic o);
      int t, c;
      t = 0;
      opt = o;
      ser = 1'b1;
      host.sel(1'b0, 1'b0);
      fork
         load_ir(IR_RELOAD);
         begin
            while (roe !== 1'b1 && t < 400) begin
               @(negedge clk);
               t++;
            end
            @(negedge clk);
            cmp_data({7'h00, poe[4]}, {7'h00, o});
            c = 1;
            while (roe === 1'b1 && c < 60) begin
               @(negedge clk);
               c++;
            end
         end
      join
      cmp_data(8'(c), 8'(RELOAD_CYC));
      host.sel(1'b1, 1'b0);
   endtask

   // Main sequence: reset, program the image, read it back every way, reload.
   initial begin
      logic [1:0] o;
      {ser, opt, tck, tms, tdi, we, addr, wdata} = '0;
      rst = 1'b1;
      void'($urandom(19));
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      cmp_data({goe, poe[6:0]}, 8'h80);
      repeat (POR_HOLD_CYC + 2) @(negedge clk);
      cmp_data({7'h00, goe}, 8'h00);
      jt(1'b0, 1'b1, o);
      load_ir(IR_ISP_ENTER);
      repeat (4) @(negedge clk);
      cmp_data({goe, poe[6:0]}, 8'h80);
      for (int i = 0; i < 16; i++) begin
         mem.push_back(8'($urandom));
         we = 1'b1;
         addr = 10'(i);
         wdata = mem[i];
         @(negedge clk);
      end
      we = 1'b0;
      load_ir(IR_ISP_EXIT);
      frame(1'b0, 16);
      frame(1'b0, 5);
      frame(1'b1, 11);
      reload(1'b0);
      reload(1'b1);
      give_verdict();
   end

   // A hang counts as a failure.
   initial begin
      #100_000;
      bad_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
